// ### rtl/adcr_control.sv
// Control, status, clock and result registers of the 10-bit converter
//
// Operation
// - Control write aborts any conversion and restarts with new settings.
// - Irq enable low: read-only done flag; set once and held in continuous.
// - Done flag clears on status/control write or result data read.
// - Irq enable high: done flag writable, 0 means interrupt; reset clears.
// - Irq enabled: interrupt per completion, cleared by data read or write.
// - Continuous bit repeats conversions back to back; else one conversion.
// - Five-bit channel select; codes 0 to 7 pick the eight port pins.
// - Unused codes give undefined results; factory test code flagged apart.
// - Two codes route internal high and low reference nodes.
// - Channel code all ones powers the converter off.
// - Left format: high holds bits 9..2, low holds bits 1..0 on top.
// - Right format: high holds bits 9..8, low holds bits 7..0.
// - Signed left format is left format with result top bit inverted.
// - Ten-bit formats: high read freezes low until read; new results lost.
// - Truncation format: low gets bits 9..2, high reads 0, no interlock.
// - Prescaler divides by 1, 2, 4, 8; top bit set divides by 16.
// - Clock select 1 picks bus clock, 0 oscillator; reset picks oscillator.
// - Justification: 00 trunc, 01 right, 10 left, 11 signed; reset right.
// - Conversion ends on the sixteenth converter clock tick, 15 to 16 cycles after start.
// - Continuous results overwrite earlier ones, read or not; the code drops them while the low byte is frozen.
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ps

module adcr_control
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// Register port
	input  wire logic [1:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	// Oscillator clock pin
	input  wire logic       oscillator_clock,
	// Analog converter side
	input  wire logic [9:0] sar_result,
	output logic      [4:0] mux_select,
	output logic            pin_channel,
	output logic            reference_channel,
	output logic            factory_test_select,
	output logic            converter_power,
	output logic            converter_clock_tick,
	output logic            converting,
	// Interrupt
	output logic            irq
);

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function automatic logic [3:0] div_limit(input logic [2:0] code);
		logic [3:0] lim;
		lim = 4'hf;
		if (code == 3'h0)
			lim = 4'h0;
		else if (code == 3'h1)
			lim = 4'h1;
		else if (code == 3'h2)
			lim = 4'h3;
		else if (code == 3'h3)
			lim = 4'h7;
		return lim;
	endfunction

	// ----------------------------------------------------------------
	// Registers and state
	// ----------------------------------------------------------------
	logic                 done_flag;
	logic                 irq_enable;
	logic                 continuous_convert;
	logic [4:0]           channel_select;
	logic [2:0]           clock_prescaler;
	logic                 input_clock_select;
	logic [1:0]           justification_select;
	logic [9:0]           result;
	logic                 low_frozen;
	logic                 irq_pending;
	logic                 osc_meta;
	logic                 osc_sync;
	logic                 osc_prev;
	logic [3:0]           div_cnt;
	logic [4:0]           tick_cnt;
	adcr_pkg::adcr_state_t state;

	logic wr_sc;
	logic wr_ck;
	logic rd_hi;
	logic rd_lo;
	logic src_tick;
	logic adc_tick;
	logic complete;
	logic store;
	logic ten_bit;

	assign wr_sc   = wr && addr == adcr_pkg::OFS_STATUS_CONTROL;
	assign wr_ck   = wr && addr == adcr_pkg::OFS_CLOCK_CONFIG;
	assign rd_hi   = rd && addr == adcr_pkg::OFS_RESULT_HIGH;
	assign rd_lo   = rd && addr == adcr_pkg::OFS_RESULT_LOW;
	assign ten_bit = justification_select != adcr_pkg::JUST_TRUNC8;

	// ----------------------------------------------------------------
	// Oscillator synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			osc_meta <= 1'b0;
			osc_sync <= 1'b0;
			osc_prev <= 1'b0;
		end
		else
		begin
			osc_meta <= oscillator_clock;
			osc_sync <= osc_meta;
			osc_prev <= osc_sync;
		end
	end

	// ----------------------------------------------------------------
	// Converter clock
	// ----------------------------------------------------------------
	// Source clock choice
	assign src_tick = input_clock_select ? 1'b1 : (osc_sync && !osc_prev);
	assign adc_tick = src_tick && div_cnt == div_limit(clock_prescaler);

	always_ff @(posedge clk)
	begin
		if (!nrst)
			div_cnt <= 4'h0;
		else if (wr_ck)
			div_cnt <= 4'h0;
		else if (adc_tick)
			div_cnt <= 4'h0;
		else if (src_tick)
			div_cnt <= div_cnt + 4'h1;
	end

	// ----------------------------------------------------------------
	// Conversion sequencer
	// ----------------------------------------------------------------
	// Sixteen ticks after start
	assign complete = state == adcr_pkg::ADCR_CONVERT && adc_tick &&
		tick_cnt == adcr_pkg::CONV_TICKS - 5'h1 && !wr_sc;

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			state    <= adcr_pkg::ADCR_IDLE;
			tick_cnt <= 5'h0;
		end
		else if (wr_sc)
		begin
			tick_cnt <= 5'h0;
			if (wdata[adcr_pkg::SC_CH_LSB +: adcr_pkg::CH_W] ==
				adcr_pkg::CH_POWER_OFF)
				state <= adcr_pkg::ADCR_IDLE;
			else
				state <= adcr_pkg::ADCR_CONVERT;
		end
		else
		begin
			case (state)
				adcr_pkg::ADCR_IDLE:
					tick_cnt <= 5'h0;
				adcr_pkg::ADCR_CONVERT:
				begin
					if (complete)
					begin
						tick_cnt <= 5'h0;
						if (!continuous_convert)
							state <= adcr_pkg::ADCR_IDLE;
					end
					else if (adc_tick)
						tick_cnt <= tick_cnt + 5'h1;
				end
				default:
					state <= adcr_pkg::ADCR_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Status and control register
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			irq_enable         <= 1'b0;
			continuous_convert <= 1'b0;
			channel_select     <= adcr_pkg::RST_CHANNEL;
		end
		else if (wr_sc)
		begin
			irq_enable         <= wdata[adcr_pkg::SC_IRQ_EN_BIT];
			continuous_convert <= wdata[adcr_pkg::SC_CONT_BIT];
			channel_select     <=
				wdata[adcr_pkg::SC_CH_LSB +: adcr_pkg::CH_W];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
			done_flag <= 1'b0;
		else if (complete)
			done_flag <= !irq_enable;
		else if (wr_sc)
			done_flag <= wdata[adcr_pkg::SC_IRQ_EN_BIT] &&
				wdata[adcr_pkg::SC_DONE_BIT];
		else if (rd_lo || rd_hi)
			done_flag <= irq_enable ? done_flag : 1'b0;
	end

	// ----------------------------------------------------------------
	// Interrupt
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!nrst)
			irq_pending <= 1'b0;
		else if (complete && irq_enable)
			irq_pending <= 1'b1;
		else if (wr_sc || rd_lo || rd_hi)
			irq_pending <= 1'b0;
	end

	assign irq = irq_pending;

	// ----------------------------------------------------------------
	// Clock config register
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			clock_prescaler      <= adcr_pkg::RST_DIV;
			input_clock_select   <= adcr_pkg::RST_CLK_SEL;
			justification_select <= adcr_pkg::RST_JUST;
		end
		else if (wr_ck)
		begin
			clock_prescaler      <=
				wdata[adcr_pkg::CK_DIV_LSB +: adcr_pkg::DIV_W];
			input_clock_select   <= wdata[adcr_pkg::CK_SEL_BIT];
			justification_select <=
				wdata[adcr_pkg::CK_JUST_LSB +: adcr_pkg::JUST_W];
		end
	end

	// ----------------------------------------------------------------
	// Result and interlock
	// ----------------------------------------------------------------
	// Drop results while frozen
	assign store = complete && !(low_frozen && ten_bit);

	always_ff @(posedge clk)
	begin
		if (!nrst)
			result <= 10'h000;
		else if (store)
			result <= sar_result;
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
			low_frozen <= 1'b0;
		else if (!ten_bit || rd_lo)
			low_frozen <= 1'b0;
		else if (rd_hi)
			low_frozen <= 1'b1;
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	logic [7:0] next_rdata;

	always_comb
	begin
		next_rdata = 8'h00;
		if (addr == adcr_pkg::OFS_STATUS_CONTROL)
		begin
			next_rdata[adcr_pkg::SC_DONE_BIT]   = done_flag;
			next_rdata[adcr_pkg::SC_IRQ_EN_BIT] = irq_enable;
			next_rdata[adcr_pkg::SC_CONT_BIT]   = continuous_convert;
			next_rdata[adcr_pkg::SC_CH_LSB +: adcr_pkg::CH_W] = channel_select;
		end
		else if (addr == adcr_pkg::OFS_RESULT_HIGH)
		begin
			case (justification_select)
				adcr_pkg::JUST_RIGHT:  next_rdata = {6'h00, result[9:8]};
				adcr_pkg::JUST_LEFT:   next_rdata = result[9:2];
				adcr_pkg::JUST_SIGNED: next_rdata = {!result[9], result[8:2]};
				default:               next_rdata = 8'h00;
			endcase
		end
		else if (addr == adcr_pkg::OFS_RESULT_LOW)
		begin
			case (justification_select)
				adcr_pkg::JUST_RIGHT:  next_rdata = result[7:0];
				adcr_pkg::JUST_LEFT:   next_rdata = {result[1:0], 6'h00};
				adcr_pkg::JUST_SIGNED: next_rdata = {result[1:0], 6'h00};
				default:               next_rdata = result[9:2];
			endcase
		end
		else if (addr == adcr_pkg::OFS_CLOCK_CONFIG)
		begin
			next_rdata[adcr_pkg::CK_DIV_LSB +: adcr_pkg::DIV_W] = clock_prescaler;
			next_rdata[adcr_pkg::CK_SEL_BIT] = input_clock_select;
			next_rdata[adcr_pkg::CK_JUST_LSB +: adcr_pkg::JUST_W] =
				justification_select;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
			rdata <= 8'h00;
		else if (rd)
			rdata <= next_rdata;
		else
			rdata <= 8'h00;
	end

	// ----------------------------------------------------------------
	// Analog side
	// ----------------------------------------------------------------
	// Channel to mux
	assign mux_select           = channel_select;
	assign pin_channel          = channel_select <= adcr_pkg::CH_PIN_LAST;
	assign reference_channel    = channel_select == adcr_pkg::CH_REF_HIGH ||
		channel_select == adcr_pkg::CH_REF_LOW;
	assign factory_test_select  = channel_select == adcr_pkg::CH_FACTORY;
	assign converter_power      = channel_select != adcr_pkg::CH_POWER_OFF;
	assign converter_clock_tick = adc_tick && converter_power;
	assign converting           = state == adcr_pkg::ADCR_CONVERT;

endmodule

// ### common/adcr_pkg.sv
// Shared constants and types for the converter control registers
package adcr_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [1:0] OFS_STATUS_CONTROL = 2'h0;
	localparam logic [1:0] OFS_RESULT_HIGH    = 2'h1;
	localparam logic [1:0] OFS_RESULT_LOW     = 2'h2;
	localparam logic [1:0] OFS_CLOCK_CONFIG   = 2'h3;

	// ----------------------------------------------------------------
	// Status and control fields
	// ----------------------------------------------------------------
	localparam int SC_DONE_BIT   = 7;
	localparam int SC_IRQ_EN_BIT = 6;
	localparam int SC_CONT_BIT   = 5;
	localparam int SC_CH_LSB     = 0;
	localparam int CH_W          = 5;

	// ----------------------------------------------------------------
	// Clock config fields
	// ----------------------------------------------------------------
	localparam int CK_DIV_LSB  = 5;
	localparam int DIV_W       = 3;
	localparam int CK_SEL_BIT  = 4;
	localparam int CK_JUST_LSB = 2;
	localparam int JUST_W      = 2;

	// ----------------------------------------------------------------
	// Channel codes
	// ----------------------------------------------------------------
	localparam logic [4:0] CH_PIN_LAST  = 5'h07;
	localparam logic [4:0] CH_FACTORY   = 5'h1b;
	localparam logic [4:0] CH_REF_HIGH  = 5'h1d;
	localparam logic [4:0] CH_REF_LOW   = 5'h1e;
	localparam logic [4:0] CH_POWER_OFF = 5'h1f;

	// ----------------------------------------------------------------
	// Justification codes
	// ----------------------------------------------------------------
	localparam logic [1:0] JUST_TRUNC8 = 2'h0;
	localparam logic [1:0] JUST_RIGHT  = 2'h1;
	localparam logic [1:0] JUST_LEFT   = 2'h2;
	localparam logic [1:0] JUST_SIGNED = 2'h3;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [4:0] RST_CHANNEL = 5'h1f;
	localparam logic [2:0] RST_DIV     = 3'h0;
	localparam logic       RST_CLK_SEL = 1'b0;
	localparam logic [1:0] RST_JUST    = 2'h1;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam logic [4:0] CONV_TICKS = 5'h10;

	typedef enum logic [0:0] {
		ADCR_IDLE,
		ADCR_CONVERT
	} adcr_state_t;

endpackage

// ### tb/adcr_control_sva.sv
// Assertion checker for the converter control registers
`timescale 1ns/1ps

module adcr_control_sva
(
	// Clock and reset
	input wire logic       clk,
	input wire logic       nrst,
	// Register port
	input wire logic [1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	// Converter side
	input wire logic [4:0] mux_select,
	input wire logic       pin_channel,
	input wire logic       reference_channel,
	input wire logic       converter_power,
	input wire logic       converting,
	input wire logic       irq
);
	logic [7:0] cfg;
	logic       ien;
	logic       sc_wr;
	logic       res_rd;
	logic       trunc_hi_rd;
	logic       right_hi_rd;
	logic       left_lo_rd;

	assign sc_wr  = wr && addr == adcr_pkg::OFS_STATUS_CONTROL;
	assign res_rd = rd && (addr == 2'h1 || addr == 2'h2);
	assign trunc_hi_rd = rd && addr == 2'h1 && cfg[3:2] == 2'h0;
	assign right_hi_rd = rd && addr == 2'h1 && cfg[3:2] == 2'h1;
	assign left_lo_rd  = rd && addr == 2'h2 && cfg[3];

	// ----------------------------------------------------------------
	// Shadow of written settings
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			cfg <= 8'h04;
			ien <= 1'b0;
		end
		else
		begin
			if (wr && addr == adcr_pkg::OFS_CLOCK_CONFIG)
				cfg <= wdata;
			if (sc_wr)
				ien <= wdata[adcr_pkg::SC_IRQ_EN_BIT];
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_power_decode:
		assert property (converter_power == (mux_select != 5'h1f))
		else $error("power output disagrees with channel");
	a_pin_decode:
		assert property (pin_channel == (mux_select <= 5'h07))
		else $error("pin channel decode wrong");
	a_ref_decode:
		assert property (reference_channel ==
			(mux_select == 5'h1d || mux_select == 5'h1e))
		else $error("reference channel decode wrong");
	a_conv_time:
		assert property (sc_wr && !wdata[5] && wdata[4:0] != 5'h1f &&
			cfg[7:4] == 4'h1 ##1 (!sc_wr)[*8] ##1 (!sc_wr)[*8] |->
			converting && $past(converting, 8) && $past(converting, 15)
			##[1:2] !converting)
		else $error("conversion length wrong");
	a_irq_at_done:
		assert property ($fell(converting) && ien && !$past(sc_wr) |-> irq)
		else $error("no interrupt at completion");
	a_irq_holds:
		assert property (irq && !sc_wr && !res_rd |=> irq)
		else $error("interrupt dropped without clearing access");
	a_write_clears:
		assert property (sc_wr |=> !irq)
		else $error("interrupt kept after control write");
	a_trunc_high:
		assert property ($past(trunc_hi_rd) |-> rdata == 8'h00)
		else $error("high result not zero in truncation");
	a_right_high:
		assert property ($past(right_hi_rd) |-> rdata[7:2] == 6'h00)
		else $error("high result upper bits set in right format");
	a_left_low:
		assert property ($past(left_lo_rd) |-> rdata[5:0] == 6'h00)
		else $error("low result lower bits set in left format");

	c_irq: cover property ($rose(irq));
	c_done: cover property ($fell(converting));
	c_trunc: cover property (rd && addr == 2'h1 && cfg[3:2] == 2'h0);
endmodule

bind adcr_control adcr_control_sva chk_u
(
	.clk              (clk),
	.nrst             (nrst),
	.addr             (addr),
	.wdata            (wdata),
	.wr               (wr),
	.rd               (rd),
	.rdata            (rdata),
	.mux_select       (mux_select),
	.pin_channel      (pin_channel),
	.reference_channel(reference_channel),
	.converter_power  (converter_power),
	.converting       (converting),
	.irq              (irq)
);

// ### tb/adcr_control_tb_top.sv
// Self-checking bench for the converter control registers
`timescale 1ns/1ps

module adcr_control_tb_top;
	logic       clk;
	logic       nrst;
	logic [1:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	logic       osc;
	logic [1:0] osc_cnt;
	logic [9:0] sar;
	logic [4:0] mux;
	logic       pin_ch;
	logic       ref_ch;
	logic       fact;
	logic       pwr;
	logic       tick;
	logic       conv;
	logic       irq;
	logic [7:0] v;
	logic [9:0] a;
	logic [9:0] b;
	int         n_mismatch;
	int         checks_done;

	adcr_control dut_u
	(
		.clk                 (clk),
		.nrst                (nrst),
		.addr                (addr),
		.wdata               (wdata),
		.wr                  (wr),
		.rd                  (rd),
		.rdata               (rdata),
		.oscillator_clock    (osc),
		.sar_result          (sar),
		.mux_select          (mux),
		.pin_channel         (pin_ch),
		.reference_channel   (ref_ch),
		.factory_test_select (fact),
		.converter_power     (pwr),
		.converter_clock_tick(tick),
		.converting          (conv),
		.irq                 (irq)
	);

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge clk)
	begin
		osc_cnt <= osc_cnt + 2'h1;
		if (osc_cnt == 2'h3)
			osc <= ~osc;
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] fmt(logic [9:0] r, logic [1:0] j,
		logic hi);
		case (j)
			2'h0: return hi ? 8'h00 : r[9:2];
			2'h1: return hi ? {6'h00, r[9:8]} : r[7:0];
			2'h2: return hi ? r[9:2] : {r[1:0], 6'h00};
			default: return hi ? {~r[9], r[8:2]} : {r[1:0], 6'h00};
		endcase
	endfunction

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		if (n_mismatch == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic wr_reg(input logic [1:0] ad, input logic [7:0] d);
		@(posedge clk);
		addr <= ad;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [1:0] ad, output logic [7:0] d);
		@(posedge clk);
		addr <= ad;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic wait_idle();
		int i;
		#1;
		for (i = 0; i < 200 && conv !== 1'b0; i++)
			@(posedge clk) #1;
		if (conv !== 1'b0)
		begin
			n_mismatch++;
			print_verdict();
		end
	endtask

	task automatic convert(input logic [7:0] d);
		wr_reg(2'h0, d);
		wait_idle();
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		int j;
		int n;
		nrst = 1'b0;
		addr = 2'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		osc = 1'b0;
		osc_cnt = 2'h0;
		sar = 10'h000;
		n_mismatch = 0;
		checks_done = 0;
		void'($urandom(32'hea4b));
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		rd_reg(2'h0, v);
		chk(v, 8'h1f);
		rd_reg(2'h3, v);
		chk(v, 8'h04);
		convert(8'h03);
		for (j = 0; j < 4; j++)
		begin
			a = 10'($urandom);
			@(posedge clk) sar <= a;
			wr_reg(2'h3, {4'h1, j[1:0], 2'h0});
			convert(8'h03);
			rd_reg(2'h0, v);
			chk(v, 8'h83);
			rd_reg(2'h1, v);
			chk(v, fmt(a, j[1:0], 1'b1));
			rd_reg(2'h2, v);
			chk(v, fmt(a, j[1:0], 1'b0));
			rd_reg(2'h0, v);
			chk(v, 8'h03);
		end
		a = 10'($urandom);
		b = ~a;
		@(posedge clk) sar <= a;
		convert(8'h00);
		rd_reg(2'h1, v);
		@(posedge clk) sar <= b;
		convert(8'h00);
		rd_reg(2'h2, v);
		chk(v, fmt(a, 2'h3, 1'b0));
		rd_reg(2'h1, v);
		chk(v, fmt(a, 2'h3, 1'b1));
		rd_reg(2'h2, v);
		wr_reg(2'h3, 8'h10);
		rd_reg(2'h1, v);
		convert(8'h00);
		rd_reg(2'h2, v);
		chk(v, b[9:2]);
		wr_reg(2'h3, 8'h14);
		convert(8'h40);
		chk({7'h0, irq}, 8'h01);
		rd_reg(2'h0, v);
		chk(v, 8'h40);
		rd_reg(2'h2, v);
		chk({7'h0, irq}, 8'h00);
		wr_reg(2'h0, 8'hc0);
		rd_reg(2'h0, v);
		chk(v, 8'hc0);
		wait_idle();
		repeat (5) @(posedge clk);
		#1 chk({7'h0, irq}, 8'h01);
		wr_reg(2'h0, 8'h5f);
		#1 chk({7'h0, irq}, 8'h00);
		a = 10'($urandom);
		@(posedge clk) sar <= a;
		wr_reg(2'h0, 8'h20);
		repeat (20) @(posedge clk);
		sar <= ~a;
		repeat (20) @(posedge clk);
		#1 chk({7'h0, conv}, 8'h01);
		rd_reg(2'h2, v);
		chk(v, ~a[7:0]);
		wr_reg(2'h0, 8'h1f);
		#1 chk({7'h0, conv}, 8'h00);
		for (j = 0; j < 32; j++)
		begin
			convert({3'h0, j[4:0]});
			chk({3'h0, mux}, {3'h0, j[4:0]});
			chk({7'h0, pin_ch}, {7'h0, (j < 8)});
			chk({7'h0, ref_ch}, {7'h0, (j == 29 || j == 30)});
			chk({7'h0, fact}, {7'h0, (j == 27)});
			chk({7'h0, pwr}, {7'h0, (j != 31)});
		end
		wr_reg(2'h0, 8'h00);
		repeat (6) @(posedge clk);
		wr_reg(2'h0, 8'h00);
		repeat (10) @(posedge clk);
		#1 chk({7'h0, conv}, 8'h01);
		wait_idle();
		for (j = 0; j < 9; j++)
		begin
			wr_reg(2'h3, j < 8 ? {j[2:0], 5'h14} : 8'h04);
			n = 0;
			repeat (64) @(posedge clk) #1 n += int'(tick);
			chk(8'(n), j < 8 ? 8'(64 >> (j[2] ? 4 : j[1:0])) : 8'h08);
		end
		print_verdict();
	end
endmodule
